// ==== src/psc_core.sv ====
// Summary of operation
// - Five processing states; power-down has sleep, software standby, hardware standby.
// - Reset outranks interrupts, interrupts outrank trap instructions.
// - A trap instruction in program execution starts trap handling, unmasked, unless an interrupt is taken at that instruction end.
// - Interrupts are sampled only at instruction end, exception-sequence end, or every cycle in sleep and software standby.
// - No interrupt sampling after condition-code logic/load instructions or right after reset.
// - Chip reset pin low abandons all processing and enters the reset state.
// - Reset handling begins when the synchronised reset pin returns high.
// - Reset handling fetches a start vector, then executes from that address.
// - All interrupts, NMI included, ignored during and just after reset handling.
// - Reset sets the interrupt mask flag; everything stays masked in reset.
// - Interrupt and trap handling push program counter then condition code on stack.
// - Then set mask flag; also user mask flag when user-bit-enable is zero.
// - After mask update, fetch the vector and branch to it.
// - Watchdog overflow enters the reset state like the reset pin.
// - While bus is released, core halts and accepts no interrupt.
// - Sleep instruction with standby-select zero enters sleep, registers kept.
// - Sleep with standby-select one: core and clock halt, peripherals reset.
// - In software standby the I/O ports hold their levels and directions.
// - Hardware standby pin low halts core and clocks, resets peripherals.
// - Standby-select is one bit, resetting to zero.
// - Trap instruction's 2-bit immediate selects the trap vector.
module psc_core (
   input  logic                       clk_in,
   input  logic                       reset_in,
   // APB slave
   input  logic                       psel_in,
   input  logic                       penable_in,
   input  logic                       pwrite_in,
   input  logic [psc_pkg::ADDR_W-1:0] paddr_in,
   input  logic [31:0]                pwdata_in,
   output logic [31:0]                prdata_out,
   output logic                       pready_out,
   output logic                       pslverr_out,
   // Pins and outside requests
   input  logic                       chip_reset_in_n,
   input  logic                       hw_standby_in_n,
   input  logic                       nmi_req_in,
   input  logic                       irq_req_in,
   input  logic                       bus_req_in,
   // Same-clock core and watchdog signals
   input  logic                       wdt_overflow_in,
   input  logic                       instr_done_in,
   input  psc_pkg::psc_icls_e         instr_class_in,
   input  logic [1:0]                 trap_imm_in,
   input  logic                       vector_ack_in,
   // State and sequence outputs
   output psc_pkg::psc_state_e        state_out,
   output psc_pkg::psc_pd_e           pd_mode_out,
   output psc_pkg::psc_kind_e         exc_kind_out,
   output logic [1:0]                 trap_num_out,
   output logic                       push_pc_out,
   output logic                       push_cc_out,
   output logic                       vector_fetch_out,
   output logic                       branch_out,
   output logic                       cc_i_out,
   output logic                       user_interrupt_mask_flag_out,
   output logic                       bus_grant_out,
   output logic                       core_run_out,
   output logic                       clock_halt_out,
   output logic                       periph_reset_out,
   output logic                       io_hold_out
);
   import psc_pkg::*;
   typedef struct packed {
      psc_state_e  st;
      psc_xstep_e  xs;
      psc_kind_e   kind;
      logic [1:0]  trap_num;
      psc_pd_e     pd;
      logic        rst_s1;
      logic        rst_s2;
      logic        sb_s1;
      logic        sb_s2;
      logic        nmi_s1;
      logic        nmi_s2;
      logic        irq_s1;
      logic        irq_s2;
      logic        breq_s1;
      logic        breq_s2;
      logic [7:0]  system_control_reg;
      logic        cc_i;
      logic        cc_ui;
      logic        post_rst_block;
      logic        push_pc;
      logic        push_cc;
      logic        vec_fetch;
      logic        branch;
      logic        grant;
      logic        clk_halt;
      logic        per_rst;
      logic        io_hold;
      logic        run;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } psc_regs_s;
   psc_regs_s q;
   psc_regs_s d;
   // Instructions after which interrupt sampling is skipped
   function automatic logic is_cc_op(input psc_icls_e cls);
      is_cc_op = cls inside {CLS_AND_TO_COND_CODE, CLS_OR_TO_COND_CODE, CLS_XOR_TO_COND_CODE, CLS_LOAD_COND_CODE};
   endfunction : is_cc_op
   // Pending interrupt that the current masks let through
   function automatic logic irq_pending(input psc_regs_s r);
      irq_pending = r.nmi_s2 || (r.irq_s2 && !r.cc_i);
   endfunction : irq_pending
   logic take_irq_boundary;
   logic take_irq_seq_end;
   // Sampling points for interrupts
   assign take_irq_boundary = instr_done_in && irq_pending(q) && !q.post_rst_block &&
                              !is_cc_op(instr_class_in);
   assign take_irq_seq_end  = (q.xs == XS_BRANCH) && (q.kind != KIND_RESET) &&
                              irq_pending(q);
   // Next-state logic
   always_comb begin
      d = q;
      // Pin synchronisers; logic reads only the second stage
      {d.rst_s2, d.rst_s1}   = {q.rst_s1, chip_reset_in_n};
      {d.sb_s2, d.sb_s1}     = {q.sb_s1, hw_standby_in_n};
      {d.nmi_s2, d.nmi_s1}   = {q.nmi_s1, nmi_req_in};
      {d.irq_s2, d.irq_s1}   = {q.irq_s1, irq_req_in};
      {d.breq_s2, d.breq_s1} = {q.breq_s1, bus_req_in};
      // APB answer one cycle into the access phase; reads have no side effect
      d.pready  = psel_in && penable_in && !q.pready;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      case (paddr_in)
         REG_SYSCTL:    d.prdata = {24'h00_0000, q.system_control_reg};
         REG_COND_CODE: d.prdata = {24'h00_0000, q.cc_i, q.cc_ui, 6'h00};
         REG_STATUS:    d.prdata = {18'h0_0000, q.grant, q.post_rst_block, q.pd, q.kind, q.trap_num, q.xs, q.st};
         default:       d.pslverr = d.pready;
      endcase
      // Writes land at the edge that samples the answer
      if (psel_in && penable_in && pwrite_in && q.pready && (paddr_in == REG_SYSCTL)) begin
         d.system_control_reg = pwdata_in[7:0];
      end
      if (psel_in && penable_in && pwrite_in && q.pready && (paddr_in == REG_COND_CODE)) begin
         {d.cc_i, d.cc_ui} = {pwdata_in[CC_I_BIT], pwdata_in[CC_UI_BIT]};
      end
      // Processing-state machine
      if (!q.sb_s2) begin
         // Hardware standby halts everything, RAM kept outside
         d.st       = ST_PWRDN;
         d.pd       = PD_HARD;
         d.xs       = XS_IDLE;
         {d.clk_halt, d.per_rst, d.io_hold, d.grant} = 4'hc;                    // Halted, peripherals reset
      end else if (q.pd == PD_HARD) begin
         // Leaving hardware standby passes through reset
         d.st       = ST_RESET;
         d.pd       = PD_NONE;
         d.clk_halt = 1'b0;
         d.cc_i     = 1'b1;
      end else if (!q.rst_s2 || wdt_overflow_in) begin
         // Abandon everything, reset outranks all but hardware standby
         d.st                 = ST_RESET;
         d.xs                 = XS_IDLE;
         d.pd                 = PD_NONE;
         d.cc_i               = 1'b1;
         d.system_control_reg = SYSCTL_RESET;
         {d.per_rst, d.clk_halt, d.io_hold, d.grant} = 4'h8;                    // Peripherals held in reset
      end else begin
         case (q.st)
            ST_RESET: begin
               // Pin back high: start reset handling at the vector fetch
               d.st      = ST_EXC;
               d.xs      = XS_VECTOR;
               d.kind    = KIND_RESET;
               d.per_rst = 1'b0;
               d.cc_i    = 1'b1;
            end
            ST_EXC: begin
               case (q.xs)
                  XS_PUSH_PC: begin
                     d.xs = XS_PUSH_CC;
                  end
                  XS_PUSH_CC: begin
                     d.xs = XS_MASK;
                  end
                  XS_MASK: begin
                     d.cc_i = 1'b1;
                     if (!q.system_control_reg[UE_BIT]) begin
                        d.cc_ui = 1'b1;
                     end
                     d.xs = XS_VECTOR;
                  end
                  XS_VECTOR: begin
                     if (q.vec_fetch && vector_ack_in) begin
                        d.xs = XS_BRANCH;
                     end
                  end
                  XS_BRANCH: begin
                     if (take_irq_seq_end) begin
                        d.xs   = XS_PUSH_PC;
                        d.kind = q.nmi_s2 ? KIND_NMI : KIND_IRQ;
                     end else begin
                        d.st = ST_EXEC;
                        d.xs = XS_IDLE;
                        if (q.kind == KIND_RESET) begin
                           d.post_rst_block = 1'b1;
                        end
                     end
                  end
                  default: begin
                     d.st = ST_EXEC;
                     d.xs = XS_IDLE;
                  end
               endcase
            end
            ST_EXEC: begin
               if (instr_done_in) begin
                  d.post_rst_block = 1'b0;
                  if (take_irq_boundary) begin
                     d.st   = ST_EXC;
                     d.xs   = XS_PUSH_PC;
                     d.kind = q.nmi_s2 ? KIND_NMI : KIND_IRQ;
                  end else if (instr_class_in == CLS_TRAP) begin
                     d.st       = ST_EXC;
                     d.xs       = XS_PUSH_PC;
                     d.kind     = KIND_TRAP;
                     d.trap_num = trap_imm_in;
                  end else if (instr_class_in == CLS_SLEEP) begin
                     d.st = ST_PWRDN;
                     if (q.system_control_reg[SOFT_STANDBY_SELECT_BIT]) begin
                        d.pd       = PD_SOFT;
                        {d.clk_halt, d.per_rst, d.io_hold} = 3'h7;
                     end else begin
                        d.pd = PD_SLEEP;
                     end
                  end else if (q.breq_s2) begin
                     d.st    = ST_BUSREL;
                     d.grant = 1'b1;
                  end
               end
            end
            ST_BUSREL: begin
               if (!q.breq_s2) begin
                  d.st    = ST_EXEC;
                  d.grant = 1'b0;
               end
            end
            ST_PWRDN: begin
               if (irq_pending(q)) begin
                  d.st       = ST_EXC;
                  d.xs       = XS_PUSH_PC;
                  d.kind     = q.nmi_s2 ? KIND_NMI : KIND_IRQ;
                  d.pd       = PD_NONE;
                  {d.clk_halt, d.per_rst, d.io_hold} = 3'h0;
               end
            end
            default: begin
               d.st = ST_RESET;
            end
         endcase
      end
      // Step strobes follow the registered step
      d.push_pc   = (d.st == ST_EXC) && (d.xs == XS_PUSH_PC);
      d.push_cc   = (d.st == ST_EXC) && (d.xs == XS_PUSH_CC);
      d.vec_fetch = (d.st == ST_EXC) && (d.xs == XS_VECTOR);
      d.branch    = (d.st == ST_EXC) && (d.xs == XS_BRANCH);
      d.run       = (d.st == ST_EXEC);
   end
   // State register
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         q                    <= '0;
         q.st                 <= ST_RESET;
         q.pd                 <= PD_NONE;
         q.xs                 <= XS_IDLE;
         q.kind               <= KIND_RESET;
         q.system_control_reg <= SYSCTL_RESET;
         q.cc_i               <= 1'b1;
         q.per_rst            <= 1'b1;
         q.rst_s1             <= 1'b0;
         q.sb_s1              <= 1'b1;
         q.sb_s2              <= 1'b1;
      end else begin
         q <= d;
      end
   end
   // Outputs straight from the state register
   assign prdata_out                   = q.prdata;
   assign pready_out                   = q.pready;
   assign pslverr_out                  = q.pslverr;
   assign state_out                    = q.st;
   assign pd_mode_out                  = q.pd;
   assign exc_kind_out                 = q.kind;
   assign trap_num_out                 = q.trap_num;
   assign push_pc_out                  = q.push_pc;
   assign push_cc_out                  = q.push_cc;
   assign vector_fetch_out             = q.vec_fetch;
   assign branch_out                   = q.branch;
   assign cc_i_out                     = q.cc_i;
   assign user_interrupt_mask_flag_out = q.cc_ui;
   assign bus_grant_out                = q.grant;
   assign core_run_out                 = q.run;
   assign clock_halt_out               = q.clk_halt;
   assign periph_reset_out             = q.per_rst;
   assign io_hold_out                  = q.io_hold;
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_stacking;
      q.push_pc ##1 q.push_cc ##1 (q.xs == XS_MASK);
   endsequence
   property p_reset_enter;
      (q.sb_s2 && q.pd != PD_HARD && (!q.rst_s2 || wdt_overflow_in)) |=> (q.st == ST_RESET);
   endproperty
   a_reset_enter: assert property (p_reset_enter) else $error("reset not entered");

   property p_reset_masked;
      (q.st == ST_RESET) |-> q.cc_i;
   endproperty
   a_reset_masked: assert property (p_reset_masked) else $error("mask clear in reset");

   property p_reset_start;
      (q.st == ST_RESET && q.sb_s2 && q.rst_s2 && !wdt_overflow_in)
         |=> (q.st == ST_EXC && q.vec_fetch && q.kind == KIND_RESET);
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("reset handling late");

   property p_trap;
      (q.st == ST_EXEC && q.sb_s2 && q.rst_s2 && !wdt_overflow_in && instr_done_in &&
       instr_class_in == CLS_TRAP && !take_irq_boundary)
         |=> (q.kind == KIND_TRAP && q.push_pc && q.trap_num == $past(trap_imm_in));
   endproperty
   a_trap: assert property (p_trap) else $error("trap not taken");

   property p_cc_op_no_irq;
      (q.st == ST_EXEC && instr_done_in && is_cc_op(instr_class_in))
         |=> !(q.push_pc && q.kind inside {KIND_IRQ, KIND_NMI});
   endproperty
   a_cc_op_no_irq: assert property (p_cc_op_no_irq) else $error("irq after cc op");

   property p_stack_order;
      (q.push_pc && q.sb_s2 && q.rst_s2 && !wdt_overflow_in) |-> s_stacking;
   endproperty
   a_stack_order: assert property (p_stack_order) else $error("stacking out of order");

   property p_user_mask;
      (q.xs == XS_MASK && q.st == ST_EXC && q.sb_s2 && q.rst_s2 && !wdt_overflow_in &&
       !q.system_control_reg[UE_BIT]) |=> (q.cc_i && q.cc_ui && q.vec_fetch);
   endproperty
   a_user_mask: assert property (p_user_mask) else $error("mask update wrong");

   property p_busrel_no_irq;
      (q.st == ST_BUSREL && q.sb_s2 && q.rst_s2) |=> (q.st != ST_EXC);
   endproperty
   a_busrel_no_irq: assert property (p_busrel_no_irq) else $error("irq while released");

   property p_sleep;
      (q.st == ST_EXEC && q.sb_s2 && q.rst_s2 && !wdt_overflow_in && instr_done_in &&
       instr_class_in == CLS_SLEEP && !take_irq_boundary && !q.system_control_reg[SOFT_STANDBY_SELECT_BIT])
         |=> (q.st == ST_PWRDN && q.pd == PD_SLEEP && !q.clk_halt);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");

   property p_hw_standby;
      !q.sb_s2 |=> (q.pd == PD_HARD && q.clk_halt && q.per_rst);
   endproperty
   a_hw_standby: assert property (p_hw_standby) else $error("standby not entered");

endmodule : psc_core

// ==== src/psc_pkg.sv ====
package psc_pkg;

   // Register offsets on the APB port
   localparam int           ADDR_W         = 12;
   localparam logic [11:0]  REG_SYSCTL     = 12'h000;
   localparam logic [11:0]  REG_COND_CODE  = 12'h004;
   localparam logic [11:0]  REG_STATUS     = 12'h008;

   // System control register fields and reset value
   localparam int           SOFT_STANDBY_SELECT_BIT       = 7;
   localparam int           UE_BIT         = 3;
   localparam logic [7:0]   SYSCTL_RESET   = 8'h09;

   // Condition code mask flag positions
   localparam int           CC_I_BIT       = 7;
   localparam int           CC_UI_BIT      = 6;

   // Processing states, Gray along reset -> exception -> execute -> released
   typedef enum logic [2:0] {
      ST_RESET   = 3'h0,
      ST_EXC     = 3'h1,
      ST_EXEC    = 3'h3,
      ST_BUSREL  = 3'h2,
      ST_PWRDN   = 3'h6
   } psc_state_e;

   // Exception sequence steps, Gray along the stacking path
   typedef enum logic [2:0] {
      XS_IDLE     = 3'h0,
      XS_PUSH_PC  = 3'h1,
      XS_PUSH_CC  = 3'h3,
      XS_MASK     = 3'h2,
      XS_VECTOR   = 3'h6,
      XS_BRANCH   = 3'h7
   } psc_xstep_e;

   // Class of the instruction that just completed
   typedef enum logic [2:0] {
      CLS_OTHER              = 3'h0,
      CLS_TRAP               = 3'h1,
      CLS_SLEEP              = 3'h2,
      CLS_AND_TO_COND_CODE   = 3'h3,
      CLS_OR_TO_COND_CODE    = 3'h4,
      CLS_XOR_TO_COND_CODE   = 3'h5,
      CLS_LOAD_COND_CODE     = 3'h6
   } psc_icls_e;

   // Exception kinds, selecting the vector group
   typedef enum logic [1:0] {
      KIND_RESET = 2'h0,
      KIND_NMI   = 2'h1,
      KIND_IRQ   = 2'h2,
      KIND_TRAP  = 2'h3
   } psc_kind_e;

   // Power-down sub-modes
   typedef enum logic [1:0] {
      PD_NONE   = 2'h0,
      PD_SLEEP  = 2'h1,
      PD_SOFT   = 2'h2,
      PD_HARD   = 2'h3
   } psc_pd_e;

endpackage : psc_pkg

// ==== test/psc_far_side.sv ====
// Far-side stand-in: vector memory and a foreign bus master
module psc_far_side (
   input  logic       clk_in,
   input  logic       reset_in,
   input  logic       vector_fetch_in,
   input  logic       bus_grant_in,
   input  logic       bus_start_in,
   input  logic [7:0] bus_len_in,
   input  logic [3:0] ack_wait_in,
   output logic       vector_ack_out,
   output logic       bus_req_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   logic [7:0] held_q;
   // Vector answer after a chosen delay; bus kept for a chosen span
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         vector_ack_out <= 1'b0;
         bus_req_out <= 1'b0;
         wait_q <= 4'h0;
         held_q <= 8'h00;
      end else begin
         vector_ack_out <= vector_fetch_in & ~vector_ack_out & (wait_q == ack_wait_in);
         wait_q <= (vector_fetch_in & ~vector_ack_out) ? wait_q + 4'h1 : 4'h0;
         if (bus_start_in) begin
            bus_req_out <= 1'b1;
         end else if (bus_grant_in && held_q == bus_len_in) begin
            bus_req_out <= 1'b0;
         end
         held_q <= bus_grant_in ? held_q + 8'h01 : 8'h00;
      end
   end
endmodule : psc_far_side

// ==== test/cpu_processing_state_control_test.sv ====
`define CHK(g,e,m) begin total_checks++; if ((g)!==(e)) begin n_fail++; $display("MISMATCH %0t %s",$time,m); end end
module cpu_processing_state_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import psc_pkg::*;
   logic clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, r;
   logic chip_reset_in_n, hw_standby_in_n, nmi_req_in, irq_req_in, bus_req_in, wdt_overflow_in;
   logic instr_done_in, vector_ack_in, push_pc_out, push_cc_out, vector_fetch_out, branch_out, e;
   logic cc_i_out, user_interrupt_mask_flag_out, bus_grant_out, core_run_out, clock_halt_out;
   logic periph_reset_out, io_hold_out, bus_start;
   logic [1:0] trap_imm_in, trap_num_out;
   logic [3:0] ack_wait;
   psc_icls_e instr_class_in;
   psc_state_e state_out;
   psc_pd_e pd_mode_out;
   psc_kind_e exc_kind_out;
   int n_fail, total_checks;
   psc_core i_dut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .chip_reset_in_n, .hw_standby_in_n, .nmi_req_in,
      .irq_req_in, .bus_req_in, .wdt_overflow_in, .instr_done_in, .instr_class_in, .trap_imm_in,
      .vector_ack_in, .state_out, .pd_mode_out, .exc_kind_out, .trap_num_out, .push_pc_out,
      .push_cc_out, .vector_fetch_out, .branch_out, .cc_i_out, .user_interrupt_mask_flag_out,
      .bus_grant_out, .core_run_out, .clock_halt_out, .periph_reset_out, .io_hold_out);
   psc_far_side i_far (.clk_in, .reset_in, .vector_fetch_in(vector_fetch_out), .bus_grant_in(bus_grant_out),
      .bus_start_in(bus_start), .bus_len_in(8'h0a), .ack_wait_in(ack_wait), .vector_ack_out(vector_ack_in),
      .bus_req_out(bus_req_in));
   // Clock and watchdog
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      #400us;
      n_fail++;
      close_out();
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in) {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
      @(posedge clk_in) penable_in <= 1'b1;
      // Answer read at the rising edge itself, before the slave updates
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      `CHK(pready_out, 1'b1, "no answer")
      r = prdata_out;
      e = pslverr_out;
      {psel_in, penable_in} <= 2'b00;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(r, x, "read data")
      `CHK(e, xe, "slave error")
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      `CHK(e, 1'b0, "write error")
   endtask : wr
   task automatic instr(input psc_icls_e c, input logic [1:0] imm);
      @(posedge clk_in) {instr_done_in, instr_class_in, trap_imm_in} <= {1'b1, c, imm};
      @(posedge clk_in) instr_done_in <= 1'b0;
      #1;
   endtask : instr
   task automatic wait_st(input psc_state_e s);
      int n;
      n = 0;
      while (state_out !== s && n < 60) begin
         step(1);
         n++;
      end
      `CHK(state_out, s, "state")
   endtask : wait_st
   // Test sequence
   initial begin
      {reset_in, chip_reset_in_n, hw_standby_in_n} = 3'b111;
      {psel_in, penable_in, pwrite_in, nmi_req_in, irq_req_in, wdt_overflow_in, instr_done_in, bus_start} = '0;
      {paddr_in, pwdata_in, trap_imm_in, ack_wait} = '0;
      instr_class_in = CLS_OTHER;
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      wait_st(ST_EXC);
      `CHK(exc_kind_out, KIND_RESET, "reset kind")
      wait_st(ST_EXEC);
      `CHK(cc_i_out, 1'b1, "mask after reset")
      rd(REG_SYSCTL, 32'h0000_0009, 1'b0);
      rd(12'h00c, 32'h0000_0000, 1'b1);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         wr(REG_SYSCTL, k[0] ? 32'h0000_0008 : 32'h0000_0000);
         wr(REG_COND_CODE, 32'h0000_0000);
         instr(CLS_TRAP, 2'(k));
         `CHK({state_out, push_pc_out, exc_kind_out}, {ST_EXC, 1'b1, KIND_TRAP}, "trap entry")
         `CHK(trap_num_out, 2'(k), "trap select")
         step(1);
         `CHK(push_cc_out, 1'b1, "cc push")
         step(2);
         `CHK({cc_i_out, user_interrupt_mask_flag_out}, {1'b1, ~k[0]}, "mask update")
         `CHK(vector_fetch_out, 1'b1, "vector fetch")
         step(2);
         `CHK(branch_out, 1'b1, "branch")
         wait_st(ST_EXEC);
      end
      $display("test trap done");
      wr(REG_COND_CODE, 32'h0000_0000);
      @(posedge clk_in) irq_req_in <= 1'b1;
      step(5);
      `CHK(state_out, ST_EXEC, "no sample mid instruction")
      for (int j = 3; j < 7; j++) begin
         instr(psc_icls_e'(j), 2'b00);
         step(1);
         `CHK(state_out, ST_EXEC, "no sample after cc op")
      end
      instr(CLS_TRAP, 2'b00);
      `CHK({state_out, exc_kind_out}, {ST_EXC, KIND_IRQ}, "interrupt over trap")
      @(posedge clk_in) irq_req_in <= 1'b0;
      wait_st(ST_EXEC);
      @(posedge clk_in) nmi_req_in <= 1'b1;
      step(4);
      instr(CLS_OTHER, 2'b00);
      `CHK(exc_kind_out, KIND_NMI, "nmi unmasked")
      @(posedge clk_in) nmi_req_in <= 1'b0;
      wait_st(ST_EXEC);
      $display("test interrupt done");
      @(posedge clk_in) bus_start <= 1'b1;
      @(posedge clk_in) bus_start <= 1'b0;
      step(3);
      instr(CLS_OTHER, 2'b00);
      `CHK({state_out, bus_grant_out, core_run_out}, {ST_BUSREL, 2'b10}, "bus released")
      @(posedge clk_in) nmi_req_in <= 1'b1;
      step(4);
      `CHK(state_out, ST_BUSREL, "no interrupt while released")
      wait_st(ST_EXEC);
      `CHK(bus_grant_out, 1'b0, "bus back")
      @(posedge clk_in) nmi_req_in <= 1'b0;
      $display("test bus done");
      for (int j = 0; j < 2; j++) begin
         wr(REG_SYSCTL, j ? 32'h0000_0088 : 32'h0000_0008);
         instr(CLS_SLEEP, 2'b00);
         step(1);
         `CHK({state_out, pd_mode_out, core_run_out}, {ST_PWRDN, j ? PD_SOFT : PD_SLEEP, 1'b0}, "sleep")
         `CHK({clock_halt_out, periph_reset_out, io_hold_out}, {3{j[0]}}, "standby outputs")
         @(posedge clk_in) nmi_req_in <= 1'b1;
         wait_st(ST_EXC);
         @(posedge clk_in) nmi_req_in <= 1'b0;
         wait_st(ST_EXEC);
      end
      rd(REG_SYSCTL, 32'h0000_0088, 1'b0);
      @(posedge clk_in) {hw_standby_in_n, ack_wait} <= {1'b0, 4'h3};
      wait_st(ST_PWRDN);
      `CHK({pd_mode_out, clock_halt_out, periph_reset_out}, {PD_HARD, 2'b11}, "hw standby")
      @(posedge clk_in) hw_standby_in_n <= 1'b1;
      wait_st(ST_RESET);
      wait_st(ST_EXEC);
      $display("test power down done");
      @(posedge clk_in) chip_reset_in_n <= 1'b0;
      step(3);
      `CHK(state_out, ST_RESET, "reset entered")
      @(posedge clk_in) nmi_req_in <= 1'b1;
      step(10);
      `CHK({state_out, vector_fetch_out, cc_i_out}, {ST_RESET, 2'b01}, "held in reset")
      @(posedge clk_in) chip_reset_in_n <= 1'b1;
      wait_st(ST_EXC);
      `CHK(exc_kind_out, KIND_RESET, "reset kind")
      wait_st(ST_EXEC);
      instr(CLS_OTHER, 2'b00);
      `CHK(state_out, ST_EXEC, "nmi blocked after reset")
      instr(CLS_OTHER, 2'b00);
      `CHK({state_out, exc_kind_out}, {ST_EXC, KIND_NMI}, "nmi later taken")
      @(posedge clk_in) nmi_req_in <= 1'b0;
      wait_st(ST_EXEC);
      @(posedge clk_in) wdt_overflow_in <= 1'b1;
      @(posedge clk_in) wdt_overflow_in <= 1'b0;
      #1;
      wait_st(ST_RESET);
      wait_st(ST_EXC);
      `CHK(exc_kind_out, KIND_RESET, "watchdog reset")
      wait_st(ST_EXEC);
      $display("test reset pin done");
      close_out();
   end
endmodule : cpu_processing_state_control_test
